// ===== cam_aux_pkg.sv
// Purpose: Constants and carrier types for the camera auxiliary register bank
// Assumes: 32-bit words, bit numbering from the MSB (bit 0 is [31])
// Notes: Offsets are byte addresses on the register port
`default_nettype none
package cam_aux_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [15:0] OFS_FRAME_INFO = 16'h12F8;
  localparam logic [15:0] OFS_XMIT_FAIL = 16'h12FC;
  localparam logic [15:0] OFS_LAMP = 16'h1A14;
  localparam logic [15:0] OFS_REGION_CTRL = 16'h1A70;
  localparam logic [15:0] OFS_REGION_PTR = 16'h1A74;
  localparam logic [15:0] OFS_REGION_BASE = 16'h1A80;
  localparam logic [15:0] OFS_POS_STEP = 16'h0000;
  localparam logic [15:0] OFS_SIZE_STEP = 16'h0004;
  localparam logic [15:0] OFS_ORIGIN = 16'h0008;
  localparam logic [15:0] OFS_EXTENT = 16'h000C;
  localparam logic [15:0] OFS_IRQ_STATUS = 16'h1A90;
  localparam logic [15:0] OFS_IRQ_MASK = 16'h1A94;
  localparam logic [15:0] OFS_LOG_FIRST = 16'h1D00;
  localparam logic [15:0] OFS_LOG_LAST = 16'h1DFF;

  // Host multiplies by four and strips the F prefix
  localparam logic [31:0] REGION_PTR_VAL = (32'h00F00000 | {16'h0000, OFS_REGION_BASE}) >> 2;

  // ****************************************
  // Field positions (MSB-first numbering; interrupt bits count from the LSB)
  // ****************************************
  localparam int PRESENCE_BIT = 0;
  localparam int FI_INQ_FIRST = 6;
  localparam int FI_ABS_BIT = 16;
  localparam int FI_EN_FIRST = 22;
  localparam int FI_ITEMS = 10;
  localparam int REGION_ON_BIT = 6;
  localparam int LAMP_WIDTH = 9;
  localparam int LOG_BYTES = 256;
  localparam int IRQ_XMIT_BIT = 0;
  localparam int IRQ_LOG_BIT = 1;
  localparam int IRQ_WIDTH = 2;

  // ****************************************
  // Values and reset values
  // ****************************************
  localparam logic [8:0] LAMP_OFF = 9'h000;
  localparam logic [8:0] LAMP_ON = 9'h074;
  localparam logic [9:0] FI_SUPPORT = 10'h3FF;
  localparam logic FI_ABS_SUPPORT = 1'b0;
  localparam logic [15:0] POS_STEP_H = 16'h0001;
  localparam logic [15:0] POS_STEP_V = 16'h0001;
  localparam logic [15:0] SIZE_STEP_H = 16'h0001;
  localparam logic [15:0] SIZE_STEP_V = 16'h0001;
  localparam logic [31:0] ORIGIN_RST = 32'h00000000;
  localparam logic [31:0] EXTENT_RST = 32'h00000000;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } busReq_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } logByte_t;

endpackage
`default_nettype wire

// ===== cam_aux_regs.sv
// Purpose: Camera auxiliary control and status register bank
// Assumes: Event inputs come from logic on clk; read data one cycle after rd
// Notes: Word bit 0 is the MSB; reserved bits read zero
//
// How it works
// - Frame-info bits 22..31 enable ten per-frame insertions, region position first.
// - Bit 0 of each feature register reads one when the feature exists.
// - Region control bit 6 enables region feature; reads back its state.
// - While region is disabled, origin and extent ignore writes.
// - Word 1A74h returns the pointer to the four region registers.
// - Base+0 gives position step: horizontal bits 0-15, vertical 16-31.
// - Base+4 gives size step: horizontal bits 0-15, vertical 16-31.
// - Base+8 holds left/top origin; base+C holds width/height extent.
// - Failure register bits 1-31 count failed frames; any write clears.
// - Log area 1D00-1DFF holds one ASCII character per byte.
// - Log stored newest-first; MSB of word 1D00h is the latest byte.
// - Lamp field bits 23-31: 0x00 turns off, 0x74 turns on.
// - Frame-info bits 6..15 flag which insertable items are supported.
// - Frame-info bit 16 selects absolute display; read-only, relative fallback.
`default_nettype none
module cam_aux_regs
  import cam_aux_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire logic [15:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Events from the image pipeline
  input wire logic xmitFail,
  input wire logic logValid,
  input wire logic [7:0] logData,
  // Settings to the image pipeline
  output logic [FI_ITEMS-1:0] insertEnable,
  output logic absoluteDisplaySelect,
  output logic exposureRegionOn,
  output logic [15:0] regionLeft,
  output logic [15:0] regionTop,
  output logic [15:0] regionWidth,
  output logic [15:0] regionHeight,
  output logic lampOn,
  // Interrupt
  output logic irq
);

  // ****************************************
  // Helpers
  // ****************************************
  // Word bit index for an MSB-first field position
  function automatic int msb(input int docBit);
    msb = 31 - docBit;
  endfunction

  function automatic logic [31:0] halves(input logic [15:0] lo, input logic [15:0] hi);
    // Doc bits 0-15 sit in the upper half of the word
    halves = {lo, hi};
  endfunction

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [31:0] rdata;
    logic [FI_ITEMS-1:0] insertEn;
    logic regionOn;
    logic [31:0] origin;
    logic [31:0] extent;
    logic [30:0] failCount;
    logic [LAMP_WIDTH-1:0] lampCode;
    logic lampOn;
    logic [IRQ_WIDTH-1:0] irqStatus;
    logic [IRQ_WIDTH-1:0] irqMask;
    logic [LOG_BYTES-1:0][7:0] logMem;
  } state_t;

  state_t cur_ff;
  state_t nxt_cur;
  busReq_t req;
  logByte_t logIn;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  assign logIn = '{valid: logValid, data: logData};

  // ****************************************
  // Address decode
  // ****************************************
  logic [15:0] regionOfs;
  logic inLog;
  logic [5:0] logWord;

  assign regionOfs = req.addr - OFS_REGION_BASE;
  assign inLog = (req.addr >= OFS_LOG_FIRST) && (req.addr <= OFS_LOG_LAST);
  assign logWord = req.addr[7:2];

  // ****************************************
  // Read view of each register
  // ****************************************
  logic [31:0] frameInfoWord;
  logic [31:0] failWord;
  logic [31:0] lampWord;
  logic [31:0] regionCtrlWord;
  logic [31:0] logWordVal;

  always_comb begin
    frameInfoWord = 32'h00000000;
    frameInfoWord[msb(PRESENCE_BIT)] = 1'b1;
    for (int i = 0; i < FI_ITEMS; i++) begin
      frameInfoWord[msb(FI_INQ_FIRST + i)] = FI_SUPPORT[FI_ITEMS-1-i];
      frameInfoWord[msb(FI_EN_FIRST + i)] = cur_ff.insertEn[FI_ITEMS-1-i];
    end
    frameInfoWord[msb(FI_ABS_BIT)] = FI_ABS_SUPPORT;

    failWord = {1'b1, cur_ff.failCount};

    lampWord = 32'h00000000;
    lampWord[msb(PRESENCE_BIT)] = 1'b1;
    lampWord[LAMP_WIDTH-1:0] = cur_ff.lampCode;

    regionCtrlWord = 32'h00000000;
    regionCtrlWord[msb(PRESENCE_BIT)] = 1'b1;
    regionCtrlWord[msb(REGION_ON_BIT)] = cur_ff.regionOn;

    // Lowest byte address, the newest byte, lands in the MSB
    logWordVal = {cur_ff.logMem[{logWord, 2'b00}], cur_ff.logMem[{logWord, 2'b01}],
                  cur_ff.logMem[{logWord, 2'b10}], cur_ff.logMem[{logWord, 2'b11}]};
  end

  // ****************************************
  // Next state
  // ****************************************
  logic [31:0] rdNext;
  logic [IRQ_WIDTH-1:0] irqEvents;

  always_comb begin
    nxt_cur = cur_ff;

    // Read mux; unmapped addresses return zero
    rdNext = 32'h00000000;
    if (inLog) begin
      rdNext = logWordVal;
    end else begin
      case (req.addr)
        OFS_FRAME_INFO: rdNext = frameInfoWord;
        OFS_XMIT_FAIL: rdNext = failWord;
        OFS_LAMP: rdNext = lampWord;
        OFS_REGION_CTRL: rdNext = regionCtrlWord;
        OFS_REGION_PTR: rdNext = REGION_PTR_VAL;
        OFS_IRQ_STATUS: rdNext = {{(32-IRQ_WIDTH){1'b0}}, cur_ff.irqStatus};
        OFS_IRQ_MASK: rdNext = {{(32-IRQ_WIDTH){1'b0}}, cur_ff.irqMask};
        default: begin
          case (regionOfs)
            OFS_POS_STEP: rdNext = halves(POS_STEP_H, POS_STEP_V);
            OFS_SIZE_STEP: rdNext = halves(SIZE_STEP_H, SIZE_STEP_V);
            OFS_ORIGIN: rdNext = cur_ff.origin;
            OFS_EXTENT: rdNext = cur_ff.extent;
            default: rdNext = 32'h00000000;
          endcase
        end
      endcase
    end
    nxt_cur.rdata = req.rd ? rdNext : 32'h00000000;

    // Register writes
    if (req.wr) begin
      case (req.addr)
        OFS_FRAME_INFO: begin
          // Unsupported items cannot be enabled
          for (int i = 0; i < FI_ITEMS; i++) begin
            nxt_cur.insertEn[FI_ITEMS-1-i] = req.wdata[msb(FI_EN_FIRST + i)]
                                             & FI_SUPPORT[FI_ITEMS-1-i];
          end
        end
        OFS_XMIT_FAIL: nxt_cur.failCount = 31'h00000000;
        OFS_LAMP: begin
          nxt_cur.lampCode = req.wdata[LAMP_WIDTH-1:0];
          // Other codes leave the lamp as it was
          if (req.wdata[LAMP_WIDTH-1:0] == LAMP_OFF) begin
            nxt_cur.lampOn = 1'b0;
          end else if (req.wdata[LAMP_WIDTH-1:0] == LAMP_ON) begin
            nxt_cur.lampOn = 1'b1;
          end
        end
        OFS_REGION_CTRL: nxt_cur.regionOn = req.wdata[msb(REGION_ON_BIT)];
        OFS_IRQ_MASK: nxt_cur.irqMask = req.wdata[IRQ_WIDTH-1:0];
        default: begin
          if (cur_ff.regionOn) begin
            if (regionOfs == OFS_ORIGIN) begin
              nxt_cur.origin = req.wdata;
            end
            if (regionOfs == OFS_EXTENT) begin
              nxt_cur.extent = req.wdata;
            end
          end
        end
      endcase
    end

    // Failure count saturates; an event in the clearing cycle still counts except when the count is saturated
    if (xmitFail && (cur_ff.failCount != 31'h7FFFFFFF)) begin
      nxt_cur.failCount = (req.wr && req.addr == OFS_XMIT_FAIL) ? 31'h00000001
                          : cur_ff.failCount + 31'h00000001;
    end

    // Newest byte enters at the start, oldest drops off the end
    if (logIn.valid) begin
      for (int i = LOG_BYTES - 1; i > 0; i--) begin
        nxt_cur.logMem[i] = cur_ff.logMem[i-1];
      end
      nxt_cur.logMem[0] = logIn.data;
    end

    // Sticky status: read clears, a new event wins
    irqEvents = '0;
    irqEvents[IRQ_XMIT_BIT] = xmitFail;
    irqEvents[IRQ_LOG_BIT] = logIn.valid;
    if (req.rd && req.addr == OFS_IRQ_STATUS) begin
      nxt_cur.irqStatus = irqEvents;
    end else begin
      nxt_cur.irqStatus = cur_ff.irqStatus | irqEvents;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_ff <= '{rdata: 32'h00000000, insertEn: '0, regionOn: 1'b0, origin: ORIGIN_RST,
                  extent: EXTENT_RST, failCount: 31'h00000000, lampCode: LAMP_OFF,
                  lampOn: 1'b0, irqStatus: '0, irqMask: '0, logMem: '0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rdata = cur_ff.rdata;
  assign insertEnable = cur_ff.insertEn;
  assign absoluteDisplaySelect = FI_ABS_SUPPORT;
  assign exposureRegionOn = cur_ff.regionOn;
  assign regionLeft = cur_ff.origin[31:16];
  assign regionTop = cur_ff.origin[15:0];
  assign regionWidth = cur_ff.extent[31:16];
  assign regionHeight = cur_ff.extent[15:0];
  assign lampOn = cur_ff.lampOn;
  assign irq = |(cur_ff.irqStatus & cur_ff.irqMask);

endmodule
`default_nettype wire

// ===== cam_aux_regs_properties.sv
// Purpose: Port properties of the camera auxiliary register bank
// Assumes: One clock domain, asynchronous reset arst_n
// Notes: Bound to every cam_aux_regs instance
`default_nettype none
module cam_aux_regs_properties
  import cam_aux_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire logic [15:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // Events
  input wire logic xmitFail,
  input wire logic logValid,
  input wire logic [7:0] logData,
  // Settings
  input wire logic [FI_ITEMS-1:0] insertEnable,
  input wire logic absoluteDisplaySelect,
  input wire logic exposureRegionOn,
  input wire logic [15:0] regionLeft,
  input wire logic [15:0] regionTop,
  input wire logic lampOn
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] ORG = OFS_REGION_BASE + OFS_ORIGIN;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ****************************************
  // Properties
  // ****************************************
  ptr_value_a: assert property (rd && addr == OFS_REGION_PTR |=> rdata == 32'h003C06A0)
    else $error("pointer word wrong");
  lamp_presence_a: assert property (rd && addr == OFS_LAMP |=> rdata[31])
    else $error("presence bit low");
  count_clear_a: assert property ((wr && addr == OFS_XMIT_FAIL && !xmitFail) ##1 !xmitFail
    ##1 (rd && addr == OFS_XMIT_FAIL && !xmitFail) |=> rdata == 32'h80000000) else $error("count not cleared");
  region_gate_a: assert property (wr && addr == ORG && !exposureRegionOn |=> $stable({regionLeft, regionTop}))
    else $error("origin written while off");
  origin_write_a: assert property (wr && addr == ORG && exposureRegionOn |=> {regionLeft, regionTop} == $past(wdata))
    else $error("origin not stored");
  region_on_a: assert property (wr && addr == OFS_REGION_CTRL |=> exposureRegionOn == $past(wdata[25]))
    else $error("region enable wrong");
  lamp_on_a: assert property (wr && addr == OFS_LAMP && wdata[8:0] == LAMP_ON |=> lampOn)
    else $error("lamp not on");
  lamp_off_a: assert property (wr && addr == OFS_LAMP && wdata[8:0] == LAMP_OFF |=> !lampOn)
    else $error("lamp not off");
  insert_en_a: assert property (wr && addr == OFS_FRAME_INFO |=> insertEnable == $past(wdata[9:0]))
    else $error("insert enables wrong");
  abs_fixed_a: assert property (!absoluteDisplaySelect)
    else $error("absolute display set");
  log_latest_a: assert property (logValid ##1 !logValid ##1 (rd && addr == OFS_LOG_FIRST)
    |=> rdata[31:24] == $past(logData, 3)) else $error("latest log byte misplaced");
  cover property (rd && addr == OFS_XMIT_FAIL);
  cover property (lampOn);
  cover property (exposureRegionOn && wr);
endmodule
bind cam_aux_regs cam_aux_regs_properties i_cam_aux_regs_properties (.clk, .arst_n, .addr, .wdata, .wr, .rd,
  .rdata, .xmitFail, .logValid, .logData, .insertEnable, .absoluteDisplaySelect, .exposureRegionOn, .regionLeft,
  .regionTop, .lampOn);
`default_nettype wire

// ===== tb_top.sv
// Purpose: Self-checking bench for the camera auxiliary register bank
// Assumes: Read data stand in the cycle after the read strobe
// Notes: Scenario order matters for interrupt status
`default_nettype none
module tb_top
  import cam_aux_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0, xmitFail = 1'b0, logValid = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wdata = 32'h00000000;
  logic [7:0] logData = 8'h00;
  logic [31:0] rdata;
  logic [9:0] insertEnable;
  logic absoluteDisplaySelect, exposureRegionOn, lampOn, irq;
  logic [15:0] regionLeft, regionTop, regionWidth, regionHeight;
  int n_fail = 0, tests_run = 0;
  cam_aux_regs i_cam_aux_regs (.clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata, .xmitFail, .logValid, .logData,
    .insertEnable, .absoluteDisplaySelect, .exposureRegionOn, .regionLeft, .regionTop, .regionWidth,
    .regionHeight, .lampOn, .irq);
  always #5 clk = ~clk;
  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [15:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk($sformatf("read %h", a), exp, rdata);
  endtask
  task automatic pulse_fail(input int n);
    @(posedge clk);
    xmitFail <= 1'b1;
    repeat (n) @(posedge clk);
    xmitFail <= 1'b0;
  endtask
  task automatic push_log(input logic [7:0] c);
    @(posedge clk);
    logValid <= 1'b1;
    logData <= c;
    @(posedge clk);
    logValid <= 1'b0;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    logic [15:0] base;
    rd_reg(OFS_FRAME_INFO, 32'h83FF0000);
    rd_reg(OFS_REGION_PTR, 32'h003C06A0);
    // Host-side base lookup: read pointer, times four, drop the F prefix
    @(posedge clk);
    rd <= 1'b1;
    addr <= OFS_REGION_PTR;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    base = 16'((rdata << 2) & 32'h000FFFFF);
    chk("region base", 32'h00001A80, {16'h0000, base});
    rd_reg(base + OFS_POS_STEP, 32'h00010001);
    rd_reg(OFS_REGION_BASE + OFS_POS_STEP, 32'h00010001);
    rd_reg(OFS_REGION_BASE + OFS_SIZE_STEP, 32'h00010001);
    rd_reg(16'h0100, 32'h00000000);
  endtask
  task automatic t_frame();
    wr_reg(OFS_FRAME_INFO, 32'hFFFFFFFF);
    rd_reg(OFS_FRAME_INFO, 32'h83FF03FF);
    chk("insertEnable", 32'h3FF, insertEnable);
    chk("absoluteDisplaySelect", 32'h0, absoluteDisplaySelect);
    wr_reg(OFS_FRAME_INFO, 32'h00000201);
    chk("insertEnable", 32'h201, insertEnable);
  endtask
  task automatic t_region();
    wr_reg(16'h1A88, 32'h00110022);
    rd_reg(16'h1A88, 32'h00000000);
    wr_reg(OFS_REGION_CTRL, 32'hFFFFFFFF);
    rd_reg(OFS_REGION_CTRL, 32'h82000000);
    wr_reg(16'h1A88, 32'h00110022);
    wr_reg(16'h1A8C, 32'h00330044);
    chk("origin", 32'h00110022, {regionLeft, regionTop});
    chk("extent", 32'h00330044, {regionWidth, regionHeight});
    wr_reg(OFS_REGION_CTRL, 32'h00000000);
    chk("exposureRegionOn", 32'h0, exposureRegionOn);
    wr_reg(16'h1A8C, 32'h00000000);
    rd_reg(16'h1A8C, 32'h00330044);
  endtask
  task automatic t_fail();
    wr_reg(OFS_IRQ_MASK, 32'h00000001);
    pulse_fail(3);
    rd_reg(OFS_XMIT_FAIL, 32'h80000003);
    chk("irq", 32'h1, irq);
    rd_reg(OFS_IRQ_STATUS, 32'h00000001);
    @(posedge clk);
    #1;
    chk("irq", 32'h0, irq);
    wr_reg(OFS_XMIT_FAIL, 32'h12345678);
    rd_reg(OFS_XMIT_FAIL, 32'h80000000);
    wr_reg(OFS_IRQ_MASK, 32'h00000000);
    pulse_fail(1);
    repeat (2) @(posedge clk);
    #1;
    chk("irq", 32'h0, irq);
  endtask
  task automatic t_log();
    for (int i = 0; i < 5; i++) begin
      push_log(8'h41 + 8'(i));
    end
    rd_reg(OFS_LOG_FIRST, 32'h45444342);
    rd_reg(16'h1D04, 32'h41000000);
    wr_reg(OFS_LOG_FIRST, 32'hFFFFFFFF);
    rd_reg(OFS_LOG_FIRST, 32'h45444342);
  endtask
  task automatic t_lamp();
    wr_reg(OFS_LAMP, 32'h00000074);
    chk("lampOn", 32'h1, lampOn);
    rd_reg(OFS_LAMP, 32'h80000074);
    wr_reg(OFS_LAMP, 32'h00000000);
    chk("lampOn", 32'h0, lampOn);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Run is under a hundred cycles; generous margin
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_frame();
    t_region();
    t_fail();
    t_log();
    t_lamp();
    complete_run();
  end
endmodule
`default_nettype wire
